//--- include/req_ctrl_cfg.svh
/*
  Offsets, field positions, reset values and sizes of the request pin control block.
  Assumes inclusion by bare name from design files.
*/
`ifndef REQ_CTRL_CFG_SVH
`define REQ_CTRL_CFG_SVH

// Register indexes; byte address is four times the index
`define REQ_IDX_PIN_CONTROL 6'h0e
`define REQ_IDX_AUX_CONTROL 6'h10
`define REQ_IDX_SNAPSHOT 6'h11
`define REQ_IDX_STATUS 6'h12

// request_pin_control fields
`define REQ_BIT_LATCH_ENABLE 0
`define REQ_BIT_PIN_FUNCTION 1
`define REQ_BIT_CAPTURE_ENABLE 2
`define REQ_BIT_UNMUTE_SELECT 8
`define REQ_PIN_CONTROL_RESET 16'h0002
`define REQ_PIN_CONTROL_MASK 16'h0107

// aux_control fields
`define REQ_BIT_WINDOW_CLEAR 0
`define REQ_BIT_SYNC_PATH_ENABLE 1
`define REQ_BIT_SUBSYSTEM_ENABLE 2
`define REQ_DELAY_LSB 8
`define REQ_DELAY_MSB 13
`define REQ_AUX_CONTROL_RESET 16'h0004
`define REQ_AUX_CONTROL_MASK 16'h3f07

// Sizes
`define REQ_SNAPSHOT_BITS 32
`define REQ_DELAY_TAPS 64

// Bus answers
`define REQ_RESP_OKAY 2'b00
`define REQ_RESP_SLVERR 2'b10

`endif

//--- include/req_ctrl_pkg.sv
/*
  Types of the request pin control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package req_ctrl_pkg;

  typedef logic [1:0] axi_resp_t;

  typedef enum logic [0:0] {
    CAP_IDLE = 1'b0,
    CAP_SHIFT = 1'b1
  } capture_state_t;

endpackage : req_ctrl_pkg

//--- include/req_window_if.sv
/*
  Interface between the request control top and its edge window capture unit.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface req_window_if #(parameter int SNAP_BITS = 32);
  logic window_clear;
  logic capture_allowed;
  logic request_rise;
  logic clock_sample;
  logic [SNAP_BITS-1:0] snapshot;
  logic armed;
  logic done;

  modport control (output window_clear, output capture_allowed, output request_rise, output clock_sample,
    input snapshot, input armed, input done);
  modport capture (input window_clear, input capture_allowed, input request_rise, input clock_sample,
    output snapshot, output armed, output done);
endinterface : req_window_if

`default_nettype wire

//--- src/edge_window_capture.sv
/*
  Edge window capture: snapshots the input clock at successive steps after a request edge.
  Assumes synchronised, same-clock inputs delivered through req_window_if.
*/
`timescale 1ns/1ps
`default_nettype none
`include "req_ctrl_cfg.svh"

module edge_window_capture #(
  parameter int SNAP_BITS = `REQ_SNAPSHOT_BITS
) (
  input wire logic aclk,
  input wire logic aresetn,
  req_window_if.capture win
);
  import req_ctrl_pkg::*;

  capture_state_t state;
  logic [$clog2(SNAP_BITS)-1:0] step;
  localparam logic [$clog2(SNAP_BITS)-1:0] LAST_STEP = ($clog2(SNAP_BITS))'(SNAP_BITS - 1);

  // Arm on clear, trigger once, shift samples in LSB first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= CAP_IDLE;
      step <= '0;
      win.snapshot <= '0;
      win.armed <= 1'b0;
      win.done <= 1'b0;
    end else if (win.window_clear) begin
      state <= CAP_IDLE;
      step <= '0;
      win.snapshot <= '0;
      win.armed <= 1'b1;
      win.done <= 1'b0;
    end else if (!win.capture_allowed) begin
      state <= CAP_IDLE; // Abort, circuit held off
      step <= '0;
    end else begin
      case (state)
        CAP_IDLE: begin
          if (win.armed && win.request_rise) begin
            state <= CAP_SHIFT; // First edge only
            win.armed <= 1'b0;
            step <= '0;
          end
        end
        CAP_SHIFT: begin
          // Boundary bits always set
          if (step == '0 || step == LAST_STEP) begin
            win.snapshot[step] <= 1'b1;
          end else begin
            win.snapshot[step] <= win.clock_sample;
          end
          if (step == LAST_STEP) begin
            state <= CAP_IDLE; // Held until next clear
            win.done <= 1'b1;
          end else begin
            step <= step + 1'b1;
          end
        end
        default: state <= CAP_IDLE;
      endcase
    end
  end

endmodule : edge_window_capture

`default_nettype wire

//--- src/sync_request_pin_control.sv
/*
  Request pin control: register slave, pin conditioning, sync/frame-reference routing,
  request latch and edge window capture.
  Assumes an AXI4-Lite master on aclk and asynchronous request and input clock pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "req_ctrl_cfg.svh"

module sync_request_pin_control #(
  parameter int SNAP_BITS = `REQ_SNAPSHOT_BITS,
  parameter int DELAY_TAPS = `REQ_DELAY_TAPS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output req_ctrl_pkg::axi_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output req_ctrl_pkg::axi_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_ref_request_input,
  input wire logic input_clock,
  output logic frame_ref_output_mute,
  output logic clock_div_sync_reset,
  output logic frame_ref_div_sync_reset,
  output logic frame_ref_request_state,
  output logic capture_power_enable
);
  import req_ctrl_pkg::*;

  // Merge one 16-bit register with write data under byte strobes and a field mask
  function automatic logic [15:0] apply_write(input logic [15:0] old, input logic [31:0] data,
                                              input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] merged;
    merged = old;
    if (strb[0]) merged[7:0] = data[7:0];
    if (strb[1]) merged[15:8] = data[15:8];
    apply_write = merged & mask;
  endfunction : apply_write

  logic [15:0] request_pin_control;
  logic [15:0] aux_control;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic [2:0] req_pipe;
  logic req_level;
  logic req_prev;
  logic [2:0] clk_pipe;
  logic clk_level;
  logic [DELAY_TAPS-1:0] delay_line;
  logic delayed_req;
  logic delayed_prev;
  logic delayed_rise;
  logic latch_state;
  logic sync_mode;
  logic sync_active;
  logic frame_ref_active;
  logic [5:0] delay_sel;

  req_window_if #(.SNAP_BITS(SNAP_BITS)) win ();

  // Write address and data taken independently, held until answered
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (aw_held && w_held && !s_axi_bvalid) begin
        w_held <= 1'b0;
      end
    end
  end

  // Register update and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      request_pin_control <= `REQ_PIN_CONTROL_RESET;
      aux_control <= `REQ_AUX_CONTROL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `REQ_RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end else if (aw_held && w_held && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `REQ_RESP_OKAY;
        case (aw_addr[7:2])
          `REQ_IDX_PIN_CONTROL: begin
            // Reserved bits dropped
            request_pin_control <= apply_write(request_pin_control, w_data, w_strb, `REQ_PIN_CONTROL_MASK);
          end
          `REQ_IDX_AUX_CONTROL: begin
            aux_control <= apply_write(aux_control, w_data, w_strb, `REQ_AUX_CONTROL_MASK);
          end
          `REQ_IDX_SNAPSHOT, `REQ_IDX_STATUS: ;
          default: s_axi_bresp <= `REQ_RESP_SLVERR;
        endcase
      end
    end
  end

  // Read channel: one read at a time, answered the cycle after it is taken
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `REQ_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `REQ_RESP_OKAY;
      case (s_axi_araddr[7:2])
        `REQ_IDX_PIN_CONTROL: s_axi_rdata <= {16'h0000, request_pin_control};
        `REQ_IDX_AUX_CONTROL: s_axi_rdata <= {16'h0000, aux_control};
        `REQ_IDX_SNAPSHOT: s_axi_rdata <= 32'(win.snapshot);
        `REQ_IDX_STATUS: s_axi_rdata <= {28'h0000000, capture_power_enable, win.armed, win.done, latch_state};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `REQ_RESP_SLVERR;
        end
      endcase
    end
  end

  // Pin conditioning: three stages, change accepted when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_pipe <= 3'h0;
      clk_pipe <= 3'h0;
      req_level <= 1'b0;
      clk_level <= 1'b0;
    end else begin
      req_pipe <= {req_pipe[1:0], frame_ref_request_input};
      clk_pipe <= {clk_pipe[1:0], input_clock};
      if (req_pipe[1] == req_pipe[2]) req_level <= req_pipe[2];
      if (clk_pipe[1] == clk_pipe[2]) clk_level <= clk_pipe[2];
    end
  end

  // Request delay line, independent of the capture enable
  assign delay_sel = aux_control[`REQ_DELAY_MSB:`REQ_DELAY_LSB];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delay_line <= '0;
      req_prev <= 1'b0;
      delayed_prev <= 1'b0;
    end else begin
      delay_line <= {delay_line[DELAY_TAPS-2:0], req_level};
      req_prev <= req_level;
      delayed_prev <= delayed_req;
    end
  end
  assign delayed_req = (delay_sel == 6'h00) ? req_level : delay_line[delay_sel - 6'h01];
  assign delayed_rise = delayed_req && !delayed_prev;

  // Path enables
  assign sync_mode = !request_pin_control[`REQ_BIT_PIN_FUNCTION];
  assign sync_active = aux_control[`REQ_BIT_SYNC_PATH_ENABLE] ||
                       (aux_control[`REQ_BIT_SUBSYSTEM_ENABLE] && sync_mode);
  assign frame_ref_active = aux_control[`REQ_BIT_SUBSYSTEM_ENABLE] && !sync_mode;

  // Request latch: set by first delayed rise, cleared by window clear, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_state <= 1'b0;
    end else if (request_pin_control[`REQ_BIT_LATCH_ENABLE] && delayed_rise) begin
      latch_state <= 1'b1;
    end else if (aux_control[`REQ_BIT_WINDOW_CLEAR]) begin
      latch_state <= 1'b0;
    end
  end

  // Outputs toward dividers and reference generator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_ref_output_mute <= 1'b0;
      clock_div_sync_reset <= 1'b0;
      frame_ref_div_sync_reset <= 1'b0;
      frame_ref_request_state <= 1'b0;
      capture_power_enable <= 1'b0;
    end else begin
      frame_ref_output_mute <= sync_mode && sync_active && !request_pin_control[`REQ_BIT_UNMUTE_SELECT];
      clock_div_sync_reset <= sync_mode && sync_active && delayed_rise;
      frame_ref_div_sync_reset <= sync_mode && sync_active && delayed_rise;
      frame_ref_request_state <= frame_ref_active &&
        (request_pin_control[`REQ_BIT_LATCH_ENABLE] ? (latch_state || delayed_rise) : delayed_req);
      capture_power_enable <= win.capture_allowed;
    end
  end

  // Window control toward the capture unit
  assign win.window_clear = aux_control[`REQ_BIT_WINDOW_CLEAR];
  assign win.capture_allowed = request_pin_control[`REQ_BIT_CAPTURE_ENABLE] &&
    (aux_control[`REQ_BIT_SYNC_PATH_ENABLE] || aux_control[`REQ_BIT_SUBSYSTEM_ENABLE]);
  assign win.request_rise = req_level && !req_prev;
  assign win.clock_sample = clk_level;

  edge_window_capture #(.SNAP_BITS(SNAP_BITS)) capture_unit (
    .aclk(aclk),
    .aresetn(aresetn),
    .win(win.capture)
  );

endmodule : sync_request_pin_control

`default_nettype wire

//--- sim/req_pin_model.sv
/*
  Model of the external controller that drives the request pin and the input clock.
  Assumes the bench calls pulse just after a rising edge of aclk.
*/
`timescale 1ns/1ps
`default_nettype none

module req_pin_model (
  input wire logic aclk,
  output logic pin,
  output logic clk_in
);
  // Pin idles low as if pulled down
  initial begin
    pin = 1'b0;
    clk_in = 1'b0;
  end

  // Free input clock, phase unrelated to aclk
  always #35 clk_in = ~clk_in;

  // One request edge, held n cycles
  task automatic pulse(input int n);
    @(posedge aclk);
    pin <= 1'b1;
    repeat (n) @(posedge aclk);
    pin <= 1'b0;
  endtask : pulse
endmodule : req_pin_model

`default_nettype wire

//--- sim/sync_request_pin_control_properties.sv
/*
  Port checker of the request pin control block.
  Assumes it is bound to sync_request_pin_control, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module sync_request_pin_control_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_ref_output_mute,
  input wire logic clock_div_sync_reset,
  input wire logic frame_ref_div_sync_reset,
  input wire logic frame_ref_request_state
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Sync event hits both divider groups together
  property p_sync_pair; clock_div_sync_reset == frame_ref_div_sync_reset; endproperty
  a_sync_pair: assert property (p_sync_pair) else $error("divider resets differ");
  property p_sync_pulse; clock_div_sync_reset |=> !clock_div_sync_reset; endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse too long");
  // Pin role excludes the other role
  property p_sync_excl; clock_div_sync_reset |-> !frame_ref_request_state; endproperty
  a_sync_excl: assert property (p_sync_excl) else $error("sync in request role");
  property p_mute_excl; frame_ref_output_mute |-> !frame_ref_request_state; endproperty
  a_mute_excl: assert property (p_mute_excl) else $error("mute in request role");
  // Bus answers
  property p_b_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("no write answer");
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_done: assert property (p_b_done) else $error("write answer stuck");
  property p_ar_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("no read answer");
  property p_ar_block; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read answer dropped");
endmodule : sync_request_pin_control_properties

bind sync_request_pin_control sync_request_pin_control_properties chk_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .frame_ref_output_mute, .clock_div_sync_reset, .frame_ref_div_sync_reset,
  .frame_ref_request_state);

`default_nettype wire

//--- sim/sync_request_pin_control_bench.sv
/*
  Self-checking bench of the request pin control block over AXI4-Lite.
  Assumes req_pin_model drives the pins and the checker is bound.
*/
`timescale 1ns/1ps
`default_nettype none
`include "req_ctrl_cfg.svh"

module sync_request_pin_control_bench;
  import req_ctrl_pkg::*;
  localparam logic [7:0] a_ctrl = 8'(`REQ_IDX_PIN_CONTROL * 4);
  localparam logic [7:0] a_aux = 8'(`REQ_IDX_AUX_CONTROL * 4);
  localparam logic [7:0] a_snap = 8'(`REQ_IDX_SNAPSHOT * 4);
  localparam logic [7:0] a_stat = 8'(`REQ_IDX_STATUS * 4);
  localparam axi_resp_t ok = `REQ_RESP_OKAY;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [3:0] wstrb = 4'h3;
  logic [31:0] wdata = 0, rdata, d, s1;
  logic awready, wready, bvalid, arready, rvalid, pin, clk_in, mute, crst, frst, rstate, cpow;
  axi_resp_t bresp, rresp, rr;
  int n_fail = 0, total_checks = 0, l0, l5;

  // Clock
  always #25 aclk = ~aclk;

  sync_request_pin_control uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frame_ref_request_input(pin),
    .input_clock(clk_in), .frame_ref_output_mute(mute), .clock_div_sync_reset(crst),
    .frame_ref_div_sync_reset(frst), .frame_ref_request_state(rstate), .capture_power_enable(cpow));

  req_pin_model pin_model (.aclk(aclk), .pin(pin), .clk_in(clk_in));

  // Verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic tmo();
    n_fail++;
    $display("unexpected wait: expected answer seen none");
    give_verdict();
  endtask : tmo

  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [15:0] v, input axi_resp_t r);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (i == 50) tmo();
    chk("write response", 32'(r), 32'(bresp));
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output axi_resp_t r);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    // Accept the answer one cycle late, so a stalled answer is exercised
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    rready <= 1'b0;
    v = rdata;
    r = rresp;
    if (i == 50) tmo();
  endtask : rd

  task automatic rc(input string w, input logic [7:0] a, input logic [31:0] e);
    rd(a, d, rr);
    chk(w, e, d);
  endtask : rc

  // Cycles from pin rise to the divider reset pulse
  task automatic lat(output int c);
    fork
      pin_model.pulse(4);
    join_none
    for (c = 0; c < 40; c++) begin
      @(posedge aclk);
      if (crst) break;
    end
    if (c == 40) tmo();
    chk("divider pair", 32'h1, 32'(frst));
    repeat (10) @(posedge aclk);
  endtask : lat

  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc("control reset", a_ctrl, 32'h0000_0002);
    rc("aux reset", a_aux, 32'h0000_0004);
    rd(8'h7c, d, rr);
    chk("unmapped resp", 32'(`REQ_RESP_SLVERR), 32'(rr));
    chk("unmapped data", 32'h0, d);
    wr(8'h7c, 16'h0000, `REQ_RESP_SLVERR);
    wr(a_ctrl, 16'h0107, ok);
    rc("control fields", a_ctrl, 32'h0000_0107);
    wr(a_ctrl, 16'h0000, ok);
    wr(a_aux, 16'h0006, ok);
    repeat (3) @(posedge aclk);
    chk("mute", 32'h1, 32'(mute));
    lat(l0);
    wr(a_aux, 16'h0506, ok);
    lat(l5);
    chk("delay cycles", 32'd5, 32'(l5 - l0));
    wr(a_ctrl, 16'h0100, ok);
    repeat (3) @(posedge aclk);
    chk("unmute", 32'h0, 32'(mute));
    // Capture after a clear, then a second edge that must not recapture
    wr(a_ctrl, 16'h0004, ok);
    wr(a_aux, 16'h0007, ok);
    wr(a_aux, 16'h0006, ok);
    chk("capture power", 32'h1, 32'(cpow));
    pin_model.pulse(4);
    repeat (50) @(posedge aclk);
    rd(a_stat, d, rr);
    chk("capture done", 32'h1, 32'(d[1]));
    chk("armed after capture", 32'h0, 32'(d[2]));
    rd(a_snap, s1, rr);
    chk("snapshot ends", 32'h8000_0001, s1 & 32'h8000_0001);
    chk("snapshot samples", 32'h0, 32'(&s1));
    pin_model.pulse(4);
    repeat (50) @(posedge aclk);
    rc("snapshot hold", a_snap, s1);
    wr(a_aux, 16'h0000, ok);
    repeat (3) @(posedge aclk);
    chk("capture off", 32'h0, 32'(cpow));
    // Sync path enable alone keeps sync and capture alive
    wr(a_aux, 16'h0002, ok);
    repeat (2) @(posedge aclk);
    chk("capture on sync path", 32'h1, 32'(cpow));
    chk("mute on sync path", 32'h1, 32'(mute));
    lat(l5);
    chk("sync path latency", 32'(l0), 32'(l5));
    // Latch in request role, then clear
    wr(a_ctrl, 16'h0003, ok);
    wr(a_aux, 16'h0004, ok);
    pin_model.pulse(4);
    repeat (20) @(posedge aclk);
    chk("latched state", 32'h1, 32'(rstate));
    wr(a_aux, 16'h0005, ok);
    repeat (3) @(posedge aclk);
    chk("cleared state", 32'h0, 32'(rstate));
    // Upper byte lane only; lower lane keeps its bits
    wstrb <= 4'h2;
    wr(a_ctrl, 16'h0100, ok);
    wstrb <= 4'h3;
    rc("byte lanes", a_ctrl, 32'h0000_0103);
    give_verdict();
  end
endmodule : sync_request_pin_control_bench

`default_nettype wire
